/* verilog/clock_unit_pkg.sv */
// constants, field layouts and carrier types of the rc calibration block
// assumes a single 25 MHz system clock and a plain register port
`default_nettype none
package clock_unit_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CLK_HZ = 25_000_000;

    // register byte addresses
    localparam logic [ADDR_W-1:0] OFS_UNIT_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_FAST_RC = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_AUX_RC = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SLOW_RC = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_CAL_CONTROL = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CAL_COUNT = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_UNIT_COMMAND = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_FLAG_CLEAR = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_INFO_PAGE = 8'h40;

    // field positions
    localparam int FAST_MODE_LSB = 0;
    localparam int SLOW_MODE_LSB = 2;
    localparam int TRIM_LSB = 0;
    localparam int BAND_LSB = 8;
    localparam int MEAS_SEL_LSB = 0;
    localparam int REF_SEL_LSB = 2;
    localparam int REPEAT_BIT = 4;
    localparam int CMD_START_BIT = 0;
    localparam int CMD_HALT_BIT = 1;
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_READY_BIT = 1;
    localparam int CLEAR_READY_BIT = 0;

    localparam int SEL_W = 2;
    localparam int SOURCE_COUNT = 4;
    localparam int CAL_W = 20;
    localparam logic [CAL_W-1:0] CAL_MAX = 20'hFFFFF;
    localparam logic [CAL_W-1:0] CAL_TOP_RESET = 20'h00001;

    localparam int BAND_W = 3;
    localparam int BAND_COUNT = 6;
    localparam int TRIM_W = 8;
    localparam int SLOW_TRIM_W = 7;
    // band 3 is the 14 MHz band, default after reset
    localparam logic [BAND_W-1:0] BAND_RESET = 3'h3;
    // factory trim per band; values arbitrary
    localparam logic [TRIM_W-1:0] FACTORY_TRIM [BAND_COUNT] =
        '{8'h2A, 8'h4C, 8'h63, 8'h7F, 8'h9B, 8'hC4};
    // slow oscillator factory trim; value arbitrary
    localparam logic [SLOW_TRIM_W-1:0] SLOW_TRIM_RESET = 7'h40;

    typedef enum logic [1:0] {
        SRC_CRYSTAL = 2'h0,
        SRC_EXT_BUFFERED = 2'h1,
        SRC_EXT_DIGITAL = 2'h2
    } source_mode_t;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b01,
        CAL_RUN = 2'b10
    } cal_state_t;

    typedef struct packed {
        logic [BAND_W-1:0] band;
        logic [TRIM_W-1:0] trim;
    } rc_setting_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic write;
        logic read;
    } reg_request_t;
endpackage : clock_unit_pkg
`default_nettype wire

/* verilog/clock_edge_detect.sv */
// turns an asynchronous oscillator level into one-cycle rising-edge ticks
// assumes the sampled clock is well below half of clk
`default_nettype none
module clock_edge_detect
    import clock_unit_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic tick
);
    logic stage1;
    logic stage2;
    logic stage3;
    logic settled;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // a change counts only once the last two stages agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            settled <= 1'b0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (stage2 == stage3 && stage3 != settled) begin
                settled <= stage3;
                tick <= stage3;
            end
        end
    end
endmodule : clock_edge_detect
`default_nettype wire

/* verilog/rc_trim_control.sv */
// band and trim holder of one fast rc oscillator
// assumes software writes a matching trim whenever it changes the band
`default_nettype none
module rc_trim_control
    import clock_unit_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic write,
    input wire logic [DATA_W-1:0] wdata,
    output rc_setting_t setting
);
    // trim drives the oscillator directly, higher code runs faster [R10]
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            setting.band <= BAND_RESET; // [R11] [R12]
            setting.trim <= FACTORY_TRIM[BAND_RESET]; // [R12]
        end else if (write) begin
            setting.band <= wdata[BAND_LSB +: BAND_W]; // [R11]
            setting.trim <= wdata[TRIM_LSB +: TRIM_W]; // [R10]
        end
    end

    property p_reset_trim;
        @(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> setting.trim == FACTORY_TRIM[BAND_RESET]
            && setting.band == BAND_RESET;
    endproperty
    a_reset_trim: assert property (p_reset_trim) // [R12]
        else $error("fast rc not at 14 MHz factory trim after reset");
endmodule : rc_trim_control
`default_nettype wire

/* verilog/rc_calibration.sv */
// rc oscillator calibration and trim block of the clock unit
// assumes oscillator clocks arrive as asynchronous levels on clock_sources
// What this block does
// (R1) start down and up counters together
// (R2) software loads top value at least one
// (R3) down counter spans top plus one ticks
// (R4) at zero capture up count, set flag
// (R5) single mode stops both counters at expiry
// (R6) repeat mode reloads top, restarts up count
// (R7) count register reads last captured value
// (R8) up counter saturates at maximum, never wraps
// (R9) halt command stops running calibration
// (R10) larger trim gives higher oscillator frequency
// (R11) fast oscillators offer selectable frequency bands
// (R12) reset loads 14 MHz band factory trim
// (R13) reset loads slow oscillator factory trim
// (R14) info page holds trim per band
// (R15) software updates trim when changing band
// (R16) crystal source modes allow external clock bypass
// (R17) ready flag sticky until software clears
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`default_nettype none
module rc_calibration
    import clock_unit_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire reg_request_t reg_request,
    output logic [DATA_W-1:0] read_data,
    input wire logic [SOURCE_COUNT-1:0] clock_sources,
    output rc_setting_t fast_rc_setting,
    output rc_setting_t aux_rc_setting,
    output logic [SLOW_TRIM_W-1:0] slow_rc_trim,
    output logic fast_crystal_bypass,
    output logic slow_crystal_bypass,
    output logic calibration_running,
    output logic calibration_ready_flag
);
    source_mode_t fast_crystal_source_mode;
    source_mode_t slow_crystal_source_mode;
    logic [SEL_W-1:0] measured_clock_select;
    logic [SEL_W-1:0] reference_clock_select;
    logic repeat_measure;
    logic [CAL_W-1:0] top_value;
    logic [CAL_W-1:0] captured;
    logic [CAL_W-1:0] down_count;
    logic [CAL_W-1:0] up_count;
    logic [CAL_W-1:0] next_up;
    cal_state_t state;
    logic ref_tick;
    logic meas_tick;
    logic wr_unit;
    logic wr_fast;
    logic wr_aux;
    logic wr_slow;
    logic wr_cal;
    logic wr_count;
    logic wr_cmd;
    logic wr_clear;
    logic start_cmd;
    logic calibration_halt_cmd;
    logic expiry;
    logic clear_ready;

    // write decode
    always_comb begin
        wr_unit = 1'b0;
        wr_fast = 1'b0;
        wr_aux = 1'b0;
        wr_slow = 1'b0;
        wr_cal = 1'b0;
        wr_count = 1'b0;
        wr_cmd = 1'b0;
        wr_clear = 1'b0;
        if (!reg_request.write) begin
            wr_unit = 1'b0;
        end else if (reg_request.addr == OFS_UNIT_CONTROL) begin
            wr_unit = 1'b1;
        end else if (reg_request.addr == OFS_FAST_RC) begin
            wr_fast = 1'b1;
        end else if (reg_request.addr == OFS_AUX_RC) begin
            wr_aux = 1'b1;
        end else if (reg_request.addr == OFS_SLOW_RC) begin
            wr_slow = 1'b1;
        end else if (reg_request.addr == OFS_CAL_CONTROL) begin
            wr_cal = 1'b1;
        end else if (reg_request.addr == OFS_CAL_COUNT) begin
            wr_count = 1'b1;
        end else if (reg_request.addr == OFS_UNIT_COMMAND) begin
            wr_cmd = 1'b1;
        end else if (reg_request.addr == OFS_FLAG_CLEAR) begin
            wr_clear = 1'b1;
        end
    end

    assign start_cmd = wr_cmd && reg_request.wdata[CMD_START_BIT];
    assign calibration_halt_cmd = wr_cmd && reg_request.wdata[CMD_HALT_BIT];
    assign clear_ready = wr_clear && reg_request.wdata[CLEAR_READY_BIT];

    rc_trim_control u_fast_rc (
        .clk(clk),
        .rst_n(rst_n),
        .write(wr_fast),
        .wdata(reg_request.wdata),
        .setting(fast_rc_setting)
    );

    rc_trim_control u_aux_rc (
        .clk(clk),
        .rst_n(rst_n),
        .write(wr_aux),
        .wdata(reg_request.wdata),
        .setting(aux_rc_setting)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            slow_rc_trim <= SLOW_TRIM_RESET; // [R13]
        end else if (wr_slow) begin
            slow_rc_trim <= reg_request.wdata[TRIM_LSB +: SLOW_TRIM_W]; // [R10]
        end
    end

    // crystal source modes; any non-crystal mode takes the pin clock as is
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fast_crystal_source_mode <= SRC_CRYSTAL;
            slow_crystal_source_mode <= SRC_CRYSTAL;
            fast_crystal_bypass <= 1'b0;
            slow_crystal_bypass <= 1'b0;
        end else if (wr_unit) begin
            fast_crystal_source_mode <= source_mode_t'(
                reg_request.wdata[FAST_MODE_LSB +: 2]);
            slow_crystal_source_mode <= source_mode_t'(
                reg_request.wdata[SLOW_MODE_LSB +: 2]);
            fast_crystal_bypass <=
                reg_request.wdata[FAST_MODE_LSB +: 2] != SRC_CRYSTAL; // [R16]
            slow_crystal_bypass <=
                reg_request.wdata[SLOW_MODE_LSB +: 2] != SRC_CRYSTAL; // [R16]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            measured_clock_select <= '0;
            reference_clock_select <= '0;
            repeat_measure <= 1'b0;
        end else if (wr_cal) begin
            measured_clock_select <= reg_request.wdata[MEAS_SEL_LSB +: SEL_W];
            reference_clock_select <= reg_request.wdata[REF_SEL_LSB +: SEL_W];
            repeat_measure <= reg_request.wdata[REPEAT_BIT];
        end
    end

    // software keeps the top value at one or more
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            top_value <= CAL_TOP_RESET;
        end else if (wr_count) begin
            top_value <= reg_request.wdata[CAL_W-1:0]; // [R2]
        end
    end

    // muxing before the synchroniser: a select change may yield one stray tick
    clock_edge_detect u_ref_edge (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(clock_sources[reference_clock_select]),
        .tick(ref_tick)
    );

    clock_edge_detect u_meas_edge (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(clock_sources[measured_clock_select]),
        .tick(meas_tick)
    );

    assign expiry = state == CAL_RUN && ref_tick && down_count == '0; // [R3]

    // saturating increment, never wraps
    always_comb begin
        next_up = up_count;
        if (meas_tick && up_count != CAL_MAX) begin
            next_up = up_count + 1'b1; // [R8]
        end
    end

    // halt wins over a start written in the same command
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= CAL_IDLE;
        end else begin
            case (state)
                CAL_IDLE: begin
                    if (start_cmd && !calibration_halt_cmd) begin
                        state <= CAL_RUN; // [R1]
                    end
                end
                CAL_RUN: begin
                    if (calibration_halt_cmd) begin
                        state <= CAL_IDLE; // [R9]
                    end else if (start_cmd) begin
                        state <= CAL_RUN;
                    end else if (expiry && !repeat_measure) begin
                        state <= CAL_IDLE; // [R5]
                    end
                end
                default: begin
                    state <= CAL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            calibration_running <= 1'b0;
        end else if (calibration_halt_cmd) begin
            calibration_running <= 1'b0; // [R9]
        end else if (start_cmd) begin
            calibration_running <= 1'b1;
        end else if (expiry && !repeat_measure) begin
            calibration_running <= 1'b0; // [R5]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            down_count <= CAL_TOP_RESET;
            up_count <= '0;
        end else if (start_cmd) begin
            down_count <= top_value; // [R1]
            up_count <= '0; // [R1]
        end else if (state == CAL_RUN && !calibration_halt_cmd) begin
            if (expiry) begin
                // single mode leaves both values frozen until the next start
                if (repeat_measure) begin
                    down_count <= top_value; // [R6]
                    up_count <= '0; // [R6]
                end
            end else begin
                up_count <= next_up; // [R8]
                if (ref_tick) begin
                    down_count <= down_count - 1'b1; // [R3]
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            captured <= '0;
        end else if (expiry && !calibration_halt_cmd) begin
            captured <= next_up; // [R4]
        end
    end

    // a capture in the clearing cycle keeps the flag set
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            calibration_ready_flag <= 1'b0;
        end else if (expiry && !calibration_halt_cmd) begin
            calibration_ready_flag <= 1'b1; // [R4] [R17]
        end else if (clear_ready) begin
            calibration_ready_flag <= 1'b0; // [R17]
        end
    end

    // read data one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            read_data <= '0;
        end else if (!reg_request.read) begin
            read_data <= '0;
        end else if (reg_request.addr == OFS_UNIT_CONTROL) begin
            read_data <= DATA_W'({slow_crystal_source_mode,
                fast_crystal_source_mode});
        end else if (reg_request.addr == OFS_FAST_RC) begin
            read_data <= DATA_W'(fast_rc_setting);
        end else if (reg_request.addr == OFS_AUX_RC) begin
            read_data <= DATA_W'(aux_rc_setting);
        end else if (reg_request.addr == OFS_SLOW_RC) begin
            read_data <= DATA_W'(slow_rc_trim);
        end else if (reg_request.addr == OFS_CAL_CONTROL) begin
            read_data <= DATA_W'({repeat_measure, reference_clock_select,
                measured_clock_select});
        end else if (reg_request.addr == OFS_CAL_COUNT) begin
            read_data <= DATA_W'(captured); // [R7]
        end else if (reg_request.addr == OFS_STATUS) begin
            read_data <= DATA_W'({calibration_ready_flag,
                calibration_running});
        end else if (reg_request.addr[7:5] == OFS_INFO_PAGE[7:5]
                && reg_request.addr[4:2] < BAND_COUNT) begin
            read_data <= DATA_W'(FACTORY_TRIM[reg_request.addr[4:2]]); // [R14]
        end else begin
            read_data <= '0;
        end
    end

    property p_start_loads;
        @(posedge clk) disable iff (!rst_n)
        start_cmd && !calibration_halt_cmd |=> state == CAL_RUN
            && up_count == '0 && down_count == $past(top_value);
    endproperty
    a_start_loads: assert property (p_start_loads) // [R1]
        else $error("start did not launch both counters");

    property p_down_step;
        @(posedge clk) disable iff (!rst_n)
        state == CAL_RUN && ref_tick && down_count != '0
            && !wr_cmd |=> down_count == $past(down_count) - 1'b1;
    endproperty
    a_down_step: assert property (p_down_step) // [R3]
        else $error("down counter did not step on reference tick");

    property p_capture;
        @(posedge clk) disable iff (!rst_n)
        expiry && !wr_cmd |=> calibration_ready_flag
            && captured == $past(next_up);
    endproperty
    a_capture: assert property (p_capture) // [R4]
        else $error("expiry did not capture and flag");

    property p_single_stop;
        @(posedge clk) disable iff (!rst_n)
        expiry && !repeat_measure && !wr_cmd |=> state == CAL_IDLE
            && !calibration_running
            ##1 ($stable(up_count) || $past(start_cmd));
    endproperty
    a_single_stop: assert property (p_single_stop) // [R5]
        else $error("single measurement kept counting");

    property p_repeat_reload;
        @(posedge clk) disable iff (!rst_n)
        expiry && repeat_measure && !wr_cmd |=> state == CAL_RUN
            && up_count == '0 && down_count == $past(top_value);
    endproperty
    a_repeat_reload: assert property (p_repeat_reload) // [R6]
        else $error("repeat mode did not reload");

    property p_count_read;
        @(posedge clk) disable iff (!rst_n)
        reg_request.read && reg_request.addr == OFS_CAL_COUNT
            |=> read_data == DATA_W'($past(captured));
    endproperty
    a_count_read: assert property (p_count_read) // [R7]
        else $error("count read did not return captured value");

    property p_saturate;
        @(posedge clk) disable iff (!rst_n)
        state == CAL_RUN && up_count == CAL_MAX && !wr_cmd && !expiry
            |=> up_count == CAL_MAX;
    endproperty
    a_saturate: assert property (p_saturate) // [R8]
        else $error("up counter wrapped");

    property p_halt;
        @(posedge clk) disable iff (!rst_n)
        calibration_halt_cmd |=> !calibration_running && state == CAL_IDLE;
    endproperty
    a_halt: assert property (p_halt) // [R9]
        else $error("halt did not stop calibration");

    property p_slow_reset;
        @(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> slow_rc_trim == SLOW_TRIM_RESET;
    endproperty
    a_slow_reset: assert property (p_slow_reset) // [R13]
        else $error("slow rc trim not at factory value");

    property p_bypass;
        @(posedge clk) disable iff (!rst_n)
        wr_unit |=> fast_crystal_bypass
            == ($past(reg_request.wdata[FAST_MODE_LSB +: 2]) != SRC_CRYSTAL);
    endproperty
    a_bypass: assert property (p_bypass) // [R16]
        else $error("fast crystal bypass does not follow mode");

    property p_sticky;
        @(posedge clk) disable iff (!rst_n)
        calibration_ready_flag && !clear_ready |=> calibration_ready_flag;
    endproperty
    a_sticky: assert property (p_sticky) // [R17]
        else $error("ready flag dropped without clear");

    c_single: cover property (@(posedge clk) disable iff (!rst_n)
        expiry && !repeat_measure);
    c_repeat: cover property (@(posedge clk) disable iff (!rst_n)
        expiry && repeat_measure ##[1:200] expiry);
    c_halt: cover property (@(posedge clk) disable iff (!rst_n)
        state == CAL_RUN && calibration_halt_cmd);
endmodule : rc_calibration
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the rc calibration block
// assumes the register map of clock_unit_pkg and a free-running clk
`default_nettype none
module testbench
    import clock_unit_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

`define check(a, b) \
    begin \
        n_checks++; \
        if ((a) !== (b)) begin \
            num_errors++; \
            $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); \
        end \
    end

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    reg_request_t req = '0;
    logic [DATA_W-1:0] read_data;
    logic [SOURCE_COUNT-1:0] clock_sources = '0;
    rc_setting_t fast_rc_setting;
    rc_setting_t aux_rc_setting;
    logic [SLOW_TRIM_W-1:0] slow_rc_trim;
    logic fast_crystal_bypass;
    logic slow_crystal_bypass;
    logic calibration_running;
    logic calibration_ready_flag;
    int num_errors = 0;
    int n_checks = 0;
    int phase = 0;
    logic [DATA_W-1:0] rd;
    logic found;

    rc_calibration DUT (
        .clk(clk),
        .rst_n(rst_n),
        .reg_request(req),
        .read_data(read_data),
        .clock_sources(clock_sources),
        .fast_rc_setting(fast_rc_setting),
        .aux_rc_setting(aux_rc_setting),
        .slow_rc_trim(slow_rc_trim),
        .fast_crystal_bypass(fast_crystal_bypass),
        .slow_crystal_bypass(slow_crystal_bypass),
        .calibration_running(calibration_running),
        .calibration_ready_flag(calibration_ready_flag)
    );

    always #20 clk = ~clk;

    // oscillators derived from clk so measured ratios are exact:
    // reference (index 2) period 20 clk, measured (index 1) period 5 clk;
    // the other two sources differ so a wrong select shows up
    always @(posedge clk) begin
        phase <= phase + 1;
        clock_sources[0] <= (phase % 7) < 3;
        clock_sources[1] <= (phase % 5) < 2;
        clock_sources[2] <= (phase % 20) < 10;
        clock_sources[3] <= (phase % 11) < 5;
    end

    task automatic reg_write(input logic [ADDR_W-1:0] a,
                             input logic [DATA_W-1:0] d);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= d;
        req.write <= 1'b1;
        @(posedge clk);
        req.write <= 1'b0;
        #1;
    endtask : reg_write

    task automatic reg_read(input logic [ADDR_W-1:0] a,
                            output logic [DATA_W-1:0] d);
        @(posedge clk);
        req.addr <= a;
        req.read <= 1'b1;
        @(posedge clk);
        req.read <= 1'b0;
        #1;
        d = read_data;
    endtask : reg_read

    task automatic expect_reg(input logic [ADDR_W-1:0] a,
                              input logic [DATA_W-1:0] e);
        reg_read(a, rd);
        `check(rd, e)
    endtask : expect_reg

    task automatic wait_ready();
        found = 1'b0;
        for (int i = 0; i < 400 && !found; i++) begin
            @(posedge clk);
            #1;
            if (calibration_ready_flag === 1'b1) found = 1'b1;
        end
    endtask : wait_ready

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    // whole sequence needs under a thousand cycles
    initial begin
        #(40 * 20000);
        num_errors++;
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // reset contents
        expect_reg(OFS_FAST_RC, 32'h0000037F);
        expect_reg(OFS_AUX_RC, 32'h0000037F);
        expect_reg(OFS_SLOW_RC, 32'h00000040);
        `check(slow_rc_trim, SLOW_TRIM_RESET)
        `check(fast_rc_setting, rc_setting_t'(11'h37F))
        expect_reg(OFS_UNIT_CONTROL, 32'h00000000);
        expect_reg(OFS_STATUS, 32'h00000000);
        expect_reg(8'h30, 32'h00000000);
        for (int n = 0; n < BAND_COUNT; n++) begin
            expect_reg(OFS_INFO_PAGE + 8'(4 * n),
                       {24'h000000, FACTORY_TRIM[n]});
        end
        // band change with matching trim, then a larger trim
        reg_write(OFS_FAST_RC, 32'h000005C4);
        `check(fast_rc_setting, rc_setting_t'(11'h5C4))
        reg_write(OFS_AUX_RC, 32'h0000002A);
        `check(aux_rc_setting, rc_setting_t'(11'h02A))
        reg_write(OFS_AUX_RC, 32'h0000002B);
        `check(aux_rc_setting.trim, 8'h2B)
        reg_write(OFS_SLOW_RC, 32'h0000007F);
        `check(slow_rc_trim, 7'h7F)
        // every source mode of both crystals
        for (int m = 0; m < 3; m++) begin
            reg_write(OFS_UNIT_CONTROL, 32'(m | ((2 - m) << 2)));
            `check(fast_crystal_bypass, m != 0)
            `check(slow_crystal_bypass, m != 2)
        end
        // single shot, top 3: window between 3 and 4 reference periods
        reg_write(OFS_CAL_CONTROL, 32'h00000009);
        // select change can give one stray tick; let it pass before start
        repeat (8) @(posedge clk);
        reg_write(OFS_CAL_COUNT, 32'h00000003);
        reg_write(OFS_UNIT_COMMAND, 32'h00000001);
        `check(calibration_running, 1'b1)
        wait_ready();
        `check(found, 1'b1)
        reg_read(OFS_CAL_COUNT, rd);
        `check(rd >= 32'd12 && rd <= 32'd16, 1'b1)
        `check(calibration_running, 1'b0)
        repeat (100) @(posedge clk);
        expect_reg(OFS_CAL_COUNT, rd);
        `check(calibration_ready_flag, 1'b1)
        reg_write(OFS_FLAG_CLEAR, 32'h00000001);
        `check(calibration_ready_flag, 1'b0)
        // repeat mode, top 2: later captures span exactly 60 clk
        reg_write(OFS_CAL_CONTROL, 32'h00000019);
        reg_write(OFS_CAL_COUNT, 32'h00000002);
        reg_write(OFS_UNIT_COMMAND, 32'h00000001);
        wait_ready();
        `check(found, 1'b1)
        repeat (80) @(posedge clk);
        expect_reg(OFS_CAL_COUNT, 32'd12);
        expect_reg(OFS_STATUS, 32'h00000003);
        reg_write(OFS_FLAG_CLEAR, 32'h00000001);
        wait_ready();
        `check(found, 1'b1)
        expect_reg(OFS_CAL_COUNT, 32'd12);
        // halt stops the run; no further captures
        reg_write(OFS_UNIT_COMMAND, 32'h00000002);
        `check(calibration_running, 1'b0)
        reg_write(OFS_FLAG_CLEAR, 32'h00000001);
        repeat (200) @(posedge clk);
        #1;
        `check(calibration_ready_flag, 1'b0)
        expect_reg(OFS_STATUS, 32'h00000000);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
